// ---- logic/uart_with_break_reset.v ----
// Serial port with configurable framing, flow control, break send and break reset
`timescale 1ns/1ps
`include "uart_break_map.vh"

// How it works
// - Characters enter on uart_rxd and leave on uart_txd, separate lines.
// - Clear-to-send in and request-to-send out are active low, used when enabled.
// - Eight data bits, parity none, odd or even, one or two stops, flow on/off.
// - Line rates from 1200 baud up to 1.5M baud within stated error.
// - Break is receive line held low; its duration is timed.
// - Break of at least the timeout setting plus one unit pulses a full device reset.
// - Software can force a break onto the transmit line.
// - A 16-bit divisor setting selects the line rate.
// - Divisor values must stay below 8192 for the receive rate generator.
module uart_with_break_reset #(
    parameter BRK_UNIT_CYC = `BRK_UNIT_US * (`CLK_HZ / 1000000)
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire uart_rxd,
    output reg uart_txd,
    input wire uart_cts_n,
    output reg uart_rts_n,
    output reg dev_reset
);
    // ----------------------------------------
    // Constants and state codes
    // ----------------------------------------
    // Cycles per reference gap, cut to the counter width on purpose
    localparam integer REF_PERIOD_I = `CLK_HZ / (`CLK_HZ - `REF_HZ) - 1;
    localparam [2:0] REF_PERIOD = REF_PERIOD_I[2:0];
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_START = 3'h1;
    localparam [2:0] S_DATA = 3'h2;
    localparam [2:0] S_PAR = 3'h3;
    localparam [2:0] S_STOP = 3'h4;
    localparam [2:0] S_HOLD = 3'h5;

    reg [`CTRL_WIDTH-1:0] ctrl_reg;
    reg [15:0] divisor_reg;
    reg [15:0] brk_tmo_reg;
    reg [2:0] ref_cnt_reg;
    reg ref_en_reg;
    wire tx_tick;
    wire rx_tick;

    reg [2:0] tx_state_reg;
    reg [7:0] tx_shift_reg;
    reg [2:0] tx_bit_reg;
    reg tx_par_reg;
    reg tx_stop2_reg;

    reg [2:0] rx_state_reg;
    reg [2:0] rx_ovs_reg;
    reg [2:0] rx_bit_reg;
    reg [7:0] rx_shift_reg;
    reg [7:0] rx_data_reg;
    reg rx_valid_reg;
    reg par_err_reg;
    reg frame_err_reg;
    reg overrun_reg;

    reg [15:0] brk_unit_reg;
    reg [15:0] brk_len_reg;
    reg brk_fired_reg;

    wire rd_rx = reg_rd && (reg_addr == `REG_RXDATA);
    wire wr_stat = reg_wr && (reg_addr == `REG_STATUS);
    wire tx_load = reg_wr && (reg_addr == `REG_TXDATA) && (tx_state_reg == S_IDLE);
    wire rx_done = rx_tick && (rx_state_reg == S_STOP) && (rx_ovs_reg == 3'h7);
    wire [15:0] status_word = {10'h000, (brk_len_reg != 16'h0000), overrun_reg,
        frame_err_reg, par_err_reg, rx_valid_reg, (tx_state_reg != S_IDLE)};

    // Parity over the data byte, inverted for odd parity
    function par_of;
        input [7:0] d;
        input odd;
        begin
            par_of = (^d) ^ odd;
        end
    endfunction

    // ----------------------------------------
    // Rate generation
    // ----------------------------------------
    // 16 MHz reference as an enable on four of every five 20 MHz cycles
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_cnt_reg <= 3'h0;
            ref_en_reg <= 1'b0;
        end else begin
            ref_cnt_reg <= (ref_cnt_reg == REF_PERIOD) ? 3'h0 : ref_cnt_reg + 3'h1;
            ref_en_reg <= (ref_cnt_reg != REF_PERIOD);
        end
    end

    // Bit rate for transmit, eight times that for receive sampling
    uart_rate_gen #(.SHIFT(0)) tx_rate (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ref_en(ref_en_reg),
        .divisor(divisor_reg),
        .tick(tx_tick)
    );

    uart_rate_gen #(.SHIFT(`RX_OVS_SHIFT)) rx_rate (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ref_en(ref_en_reg),
        .divisor(divisor_reg),
        .tick(rx_tick)
    );

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    // Writes to configuration registers; data only meaningful on the read cycle after
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= `CTRL_RESET;
            divisor_reg <= `DIVISOR_RESET;
            brk_tmo_reg <= `BRK_TMO_RESET;
            reg_rdata <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == `REG_CTRL)
                ctrl_reg <= reg_wdata[`CTRL_WIDTH-1:0];
            if (reg_wr && reg_addr == `REG_DIVISOR)
                divisor_reg <= reg_wdata;
            if (reg_wr && reg_addr == `REG_BRK_TIMEOUT)
                brk_tmo_reg <= reg_wdata;
            if (reg_rd) begin
                case (reg_addr)
                    `REG_CTRL: reg_rdata <= {11'h000, ctrl_reg};
                    `REG_DIVISOR: reg_rdata <= divisor_reg;
                    `REG_BRK_TIMEOUT: reg_rdata <= brk_tmo_reg;
                    `REG_RXDATA: reg_rdata <= {8'h00, rx_data_reg};
                    `REG_STATUS: reg_rdata <= status_word;
                    default: reg_rdata <= 16'h0000;
                endcase
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    // Frame starts on the next bit tick, so first bit may be up to one bit late
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state_reg <= S_IDLE;
            tx_shift_reg <= 8'h00;
            tx_bit_reg <= 3'h0;
            tx_par_reg <= 1'b0;
            tx_stop2_reg <= 1'b0;
            uart_txd <= 1'b1;
        end else begin
            case (tx_state_reg)
                S_IDLE: begin
                    if (tx_load) begin
                        tx_shift_reg <= reg_wdata[7:0];
                        tx_par_reg <= par_of(reg_wdata[7:0], ctrl_reg[`CTRL_PAR_ODD]);
                        tx_state_reg <= S_START;
                    end
                end
                S_START: begin
                    // Hold off while the far end deasserts clear-to-send
                    if (tx_tick && !ctrl_reg[`CTRL_SEND_BRK] &&
                            !(ctrl_reg[`CTRL_FLOW_EN] && uart_cts_n)) begin
                        tx_bit_reg <= 3'h0;
                        tx_state_reg <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (tx_tick) begin
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        tx_bit_reg <= tx_bit_reg + 3'h1;
                        if (tx_bit_reg == 3'h7) begin
                            tx_stop2_reg <= ctrl_reg[`CTRL_TWO_STOP];
                            tx_state_reg <= ctrl_reg[`CTRL_PAR_EN] ? S_PAR : S_STOP;
                        end
                    end
                end
                S_PAR: begin
                    if (tx_tick)
                        tx_state_reg <= S_STOP;
                end
                S_STOP: begin
                    if (tx_tick) begin
                        tx_stop2_reg <= 1'b0;
                        if (!tx_stop2_reg)
                            tx_state_reg <= S_IDLE;
                    end
                end
                default: tx_state_reg <= S_IDLE;
            endcase
            // Line level follows the state at each bit boundary
            if (ctrl_reg[`CTRL_SEND_BRK] && tx_state_reg == S_IDLE)
                uart_txd <= 1'b0;
            else if (tx_tick) begin
                case (tx_state_reg)
                    S_START: uart_txd <= ctrl_reg[`CTRL_SEND_BRK] |
                        (ctrl_reg[`CTRL_FLOW_EN] & uart_cts_n) ? 1'b1 : 1'b0;
                    S_DATA: uart_txd <= tx_shift_reg[0]; // LSB first, shifted on the same tick
                    S_PAR: uart_txd <= tx_par_reg;
                    default: uart_txd <= 1'b1;
                endcase
            end else if (tx_state_reg == S_IDLE)
                uart_txd <= 1'b1;
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    // Eight samples per bit; data sampled near mid-bit
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_state_reg <= S_IDLE;
            rx_ovs_reg <= 3'h0;
            rx_bit_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_data_reg <= 8'h00;
            rx_valid_reg <= 1'b0;
            par_err_reg <= 1'b0;
            frame_err_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            // Error flags clear by writing ones; a new event below still wins
            if (wr_stat) begin
                par_err_reg <= par_err_reg & ~reg_wdata[`STAT_PAR_ERR];
                frame_err_reg <= frame_err_reg & ~reg_wdata[`STAT_FRAME_ERR];
                overrun_reg <= overrun_reg & ~reg_wdata[`STAT_OVERRUN];
            end
            if (rd_rx)
                rx_valid_reg <= 1'b0;
            if (rx_tick) begin
                rx_ovs_reg <= rx_ovs_reg + 3'h1;
                case (rx_state_reg)
                    S_IDLE: begin
                        rx_ovs_reg <= 3'h0;
                        if (!uart_rxd)
                            rx_state_reg <= S_START;
                    end
                    S_START: begin
                        if (rx_ovs_reg == 3'h3) begin
                            rx_ovs_reg <= 3'h0;
                            rx_bit_reg <= 3'h0;
                            rx_state_reg <= uart_rxd ? S_IDLE : S_DATA;
                        end
                    end
                    S_DATA: begin
                        if (rx_ovs_reg == 3'h7) begin
                            rx_shift_reg <= {uart_rxd, rx_shift_reg[7:1]};
                            rx_bit_reg <= rx_bit_reg + 3'h1;
                            if (rx_bit_reg == 3'h7)
                                rx_state_reg <= ctrl_reg[`CTRL_PAR_EN] ? S_PAR : S_STOP;
                        end
                    end
                    S_PAR: begin
                        if (rx_ovs_reg == 3'h7) begin
                            if (uart_rxd != par_of(rx_shift_reg, ctrl_reg[`CTRL_PAR_ODD]))
                                par_err_reg <= 1'b1;
                            rx_state_reg <= S_STOP;
                        end
                    end
                    S_STOP: begin
                        if (rx_ovs_reg == 3'h7) begin
                            if (!uart_rxd) begin
                                frame_err_reg <= 1'b1;
                                rx_state_reg <= S_HOLD;
                            end else begin
                                rx_state_reg <= S_IDLE;
                            end
                        end
                    end
                    S_HOLD: begin
                        // Wait out a break so it does not frame endless characters
                        if (uart_rxd)
                            rx_state_reg <= S_IDLE;
                    end
                    default: rx_state_reg <= S_IDLE;
                endcase
            end
            if (rx_done && uart_rxd) begin
                rx_data_reg <= rx_shift_reg;
                rx_valid_reg <= 1'b1;
                if (rx_valid_reg && !rd_rx)
                    overrun_reg <= 1'b1;
            end
        end
    end

    // Ready to receive while the holding register is empty
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            uart_rts_n <= 1'b1;
        else
            uart_rts_n <= ctrl_reg[`CTRL_FLOW_EN] & rx_valid_reg;
    end

    // ----------------------------------------
    // Break timing and reset
    // ----------------------------------------
    // Low time counted in units; one reset pulse per break
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            brk_unit_reg <= 16'h0000;
            brk_len_reg <= 16'h0000;
            brk_fired_reg <= 1'b0;
            dev_reset <= 1'b0;
        end else begin
            dev_reset <= 1'b0;
            if (uart_rxd) begin
                brk_unit_reg <= 16'h0000;
                brk_len_reg <= 16'h0000;
                brk_fired_reg <= 1'b0;
            end else begin
                if (brk_unit_reg == BRK_UNIT_CYC[15:0] - 16'h0001) begin
                    brk_unit_reg <= 16'h0000;
                    if (brk_len_reg != 16'hffff)
                        brk_len_reg <= brk_len_reg + 16'h0001;
                end else begin
                    brk_unit_reg <= brk_unit_reg + 16'h0001;
                end
                if (brk_len_reg > brk_tmo_reg && !brk_fired_reg) begin
                    dev_reset <= 1'b1;
                    brk_fired_reg <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- logic/uart_break_map.vh ----
// Register offsets, field positions, reset values and timing for the serial port
`ifndef UART_BREAK_MAP_VH
`define UART_BREAK_MAP_VH

// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define REG_CTRL        4'h0
`define REG_DIVISOR     4'h1
`define REG_BRK_TIMEOUT 4'h2
`define REG_TXDATA      4'h3
`define REG_RXDATA      4'h4
`define REG_STATUS      4'h5

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_PAR_EN     0
`define CTRL_PAR_ODD    1
`define CTRL_TWO_STOP   2
`define CTRL_FLOW_EN    3
`define CTRL_SEND_BRK   4
`define CTRL_WIDTH      5

// ----------------------------------------
// Status fields
// ----------------------------------------
`define STAT_TX_BUSY    0
`define STAT_RX_VALID   1
`define STAT_PAR_ERR    2
`define STAT_FRAME_ERR  3
`define STAT_OVERRUN    4
`define STAT_BRK_ACTIVE 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RESET      5'h00
`define DIVISOR_RESET   16'h01d8
`define BRK_TMO_RESET   16'h0064

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ          20000000
`define REF_HZ          16000000
`define BRK_UNIT_US     1000
`define RX_OVS_SHIFT    3

`endif

// ---- logic/uart_rate_gen.v ----
// Phase accumulator rate generator: one tick per accumulator overflow
`timescale 1ns/1ps
module uart_rate_gen #(
    parameter SHIFT = 0
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire ref_en,
    input wire [15:0] divisor,
    output reg tick
);
    reg [15:0] acc_reg;
    wire [15:0] addend;
    wire [16:0] sum;

    // Oversampled copies scale the divisor; divisors must stay below 2^(16-SHIFT)
    assign addend = divisor << SHIFT;
    assign sum = {1'b0, acc_reg} + {1'b0, addend};

    // Within that limit the carry rate is (divisor << SHIFT) * ref / 65536
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_reg <= 16'h0000;
            tick <= 1'b0;
        end else if (ref_en) begin
            acc_reg <= sum[15:0];
            tick <= sum[16];
        end else begin
            tick <= 1'b0;
        end
    end
endmodule

// ---- verif/uart_brk_asserts.sv ----
// Concurrent checks on the serial port pins and register port
`timescale 1ns/1ps
`include "uart_break_map.vh"
module uart_brk_chk #(
    parameter BRK_UNIT_CYC = 20000
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire uart_rxd,
    input wire uart_txd,
    input wire uart_cts_n,
    input wire uart_rts_n,
    input wire dev_reset
);
reg [4:0] c_reg;
reg [15:0] div_reg;
reg [15:0] tmo_reg;
reg [31:0] lo_reg;
reg [1:0] up_reg;
// ----
// Shadows
// ----
// Mirror of the writable settings; readback and break timing are judged against it
always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
        c_reg <= `CTRL_RESET;
        div_reg <= `DIVISOR_RESET;
        tmo_reg <= `BRK_TMO_RESET;
        lo_reg <= 32'h0;
        up_reg <= 2'h0;
    end else begin
        if (reg_wr && reg_addr == `REG_CTRL) c_reg <= reg_wdata[4:0];
        if (reg_wr && reg_addr == `REG_DIVISOR) div_reg <= reg_wdata;
        if (reg_wr && reg_addr == `REG_BRK_TIMEOUT) tmo_reg <= reg_wdata;
        lo_reg <= uart_rxd ? 32'h0 : lo_reg + 32'h1; // Length of the current low run
        up_reg <= up_reg + {1'b0, ~&up_reg}; // Masks the edges right after reset
    end
end
// ----
// Properties
// ----
default clocking cb @(posedge ref_clk); endclocking
default disable iff (sys_rst);
property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
endproperty
a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
property p_unmap;
    reg_rd && reg_addr > `REG_STATUS |=> reg_rdata == 16'h0000;
endproperty
a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
property p_stat_hi;
    reg_rd && reg_addr == `REG_STATUS |=> reg_rdata[15:6] == 10'h000;
endproperty
a_stat_hi: assert property (p_stat_hi) else $error("status upper bits set");
property p_rx_hi;
    reg_rd && reg_addr == `REG_RXDATA |=> reg_rdata[15:8] == 8'h00;
endproperty
a_rx_hi: assert property (p_rx_hi) else $error("receive upper bits set");
property p_ctrl_rb;
    reg_rd && reg_addr == `REG_CTRL |=> reg_rdata == {11'h000, c_reg};
endproperty
a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
property p_div_rb;
    reg_rd && reg_addr == `REG_DIVISOR |=> reg_rdata == div_reg;
endproperty
a_div_rb: assert property (p_div_rb) else $error("divisor readback wrong");
property p_tmo_rb;
    reg_rd && reg_addr == `REG_BRK_TIMEOUT |=> reg_rdata == tmo_reg;
endproperty
a_tmo_rb: assert property (p_tmo_rb) else $error("timeout readback wrong");
property p_rts_off;
    up_reg == 2'h3 && !c_reg[`CTRL_FLOW_EN] && !$past(c_reg[`CTRL_FLOW_EN]) |-> !uart_rts_n;
endproperty
a_rts_off: assert property (p_rts_off) else $error("rts high without flow");
property p_brk_tx;
    $rose(c_reg[`CTRL_SEND_BRK]) |-> ##[1:1000] !uart_txd;
endproperty
a_brk_tx: assert property (p_brk_tx) else $error("break not driven");
property p_rst_once;
    dev_reset |=> !dev_reset;
endproperty
a_rst_once: assert property (p_rst_once) else $error("reset pulse too long");
property p_rst_cause;
    dev_reset |-> lo_reg + 32'h3 >= (tmo_reg + 32'h1) * BRK_UNIT_CYC;
endproperty
a_rst_cause: assert property (p_rst_cause) else $error("reset before timeout");
endmodule
bind uart_with_break_reset uart_brk_chk #(.BRK_UNIT_CYC(BRK_UNIT_CYC)) u_uart_brk_chk (
    .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .uart_rxd, .uart_txd, .uart_cts_n, .uart_rts_n, .dev_reset);

// ---- verif/serial_peer.sv ----
// Behavioural far-end serial device facing the port
`timescale 1ns/1ps
module serial_peer #(
    parameter BIT = 20
) (
    input wire clk,
    input wire txd,
    output reg rxd,
    output reg cts_n,
    input wire rts_n
);
reg [9:0] got;
integer n_got;
integer i;
integer j;
// Idle line high and ready to take characters
initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
    n_got = 0;
end
// Receive on its own line: sample mid-bit, LSB first, ten bits after start
always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (i = 0; i < 10; i = i + 1) begin
        repeat (BIT) @(posedge clk);
        got[i] = txd;
    end
    n_got = n_got + 1;
    wait (txd === 1'b1);
end
// Send a whole frame; holds off while the port says it cannot receive
task send(input [11:0] f);
begin
    wait (rts_n === 1'b0);
    for (j = 0; j < 12; j = j + 1) begin
        @(posedge clk);
        rxd <= f[j];
        repeat (BIT - 1) @(posedge clk);
    end
end
endtask
// Break: hold the line low for n cycles
task hold_low(input integer n);
begin
    @(posedge clk);
    rxd <= 1'b0;
    repeat (n) @(posedge clk);
    rxd <= 1'b1;
end
endtask
// Clear-to-send level; only this model drives the pin
task set_cts(input v);
begin
    cts_n <= v;
end
endtask
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the serial port with break reset
`timescale 1ns/1ps
`include "uart_break_map.vh"
module tb_top;
reg ref_clk = 1'b0;
reg sys_rst = 1'b0;
reg [3:0] reg_addr = 4'h0;
reg [15:0] reg_wdata = 16'h0000;
reg reg_wr = 1'b0;
reg reg_rd = 1'b0;
wire [15:0] reg_rdata;
wire uart_rxd, uart_txd, uart_cts_n, uart_rts_n, dev_reset;
integer miscompares = 0;
integer total_checks = 0;
integer pulses = 0;
integer k, m, n0;
reg [15:0] v;
reg [7:0] d;
reg [4:0] c;
always #25 ref_clk = ~ref_clk;
// Short break unit keeps the run small
uart_with_break_reset #(.BRK_UNIT_CYC(20)) u_uart_with_break_reset (.ref_clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .uart_rxd, .uart_txd,
    .uart_cts_n, .uart_rts_n, .dev_reset);
serial_peer #(.BIT(20)) u_serial_peer (.clk(ref_clk), .txd(uart_txd), .rxd(uart_rxd),
    .cts_n(uart_cts_n), .rts_n(uart_rts_n));
// Count device reset pulses
always @(posedge ref_clk) if (dev_reset === 1'b1) pulses <= pulses + 1;
// ----
// Shared tasks
// ----
task chk(input [15:0] got, input [15:0] exp);
begin
    total_checks = total_checks + 1;
    if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
end
endtask
task wr(input [3:0] a, input [15:0] w);
begin
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
end
endtask
// Read data stands only in the cycle after the strobe, so sample just past that edge
task rchk(input [3:0] a, input [15:0] msk, input [15:0] e);
begin
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    chk(v & msk, e);
end
endtask
task wait_got(input integer n);
begin
    for (k = 0; k < 3000 && u_serial_peer.n_got != n; k = k + 1) @(posedge ref_clk);
    chk(u_serial_peer.n_got[15:0], n[15:0]);
end
endtask
// ----
// Scenarios
// ----
task t_reset;
begin
    rchk(`REG_CTRL, 16'hffff, {11'h000, `CTRL_RESET});
    rchk(`REG_DIVISOR, 16'hffff, `DIVISOR_RESET);
    rchk(`REG_BRK_TIMEOUT, 16'hffff, `BRK_TMO_RESET);
    rchk(4'hf, 16'hffff, 16'h0000);
    chk({15'h0000, uart_rts_n}, 16'h0000);
    wr(`REG_DIVISOR, 16'h1000); // Not a standard rate: 20 clocks a bit
    rchk(`REG_DIVISOR, 16'hffff, 16'h1000);
end
endtask
// No parity, even parity, odd parity and two stop bits; a second write while busy must be dropped
task t_tx;
for (m = 0; m < 4; m = m + 1) begin
    c = (m == 3) ? 5'h04 : {3'h0, m[1], m[1] | m[0]};
    d = 8'h35 + {m[1:0], 6'h00};
    n0 = u_serial_peer.n_got;
    wr(`REG_CTRL, {11'h000, c});
    wr(`REG_TXDATA, {8'h00, d});
    rchk(`REG_STATUS, 16'h0001, 16'h0001);
    wr(`REG_TXDATA, {8'h00, ~d});
    wait_got(n0 + 1);
    // Busy ends as the last stop bit starts, before the peer's tenth sample
    rchk(`REG_STATUS, 16'h0001, 16'h0000);
    chk({8'h00, u_serial_peer.got[7:0]}, {8'h00, d});
    chk({15'h0000, u_serial_peer.got[8]}, {15'h0000, c[0] ? ^d ^ c[1] : 1'b1});
    chk({15'h0000, u_serial_peer.got[9]}, 16'h0001);
    repeat (300) @(posedge ref_clk);
    chk(u_serial_peer.n_got[15:0], n0[15:0] + 16'h1);
end
endtask
// Flow control both ways
task t_flow;
begin
    wr(`REG_CTRL, 16'h0008);
    u_serial_peer.set_cts(1'b1);
    n0 = u_serial_peer.n_got;
    wr(`REG_TXDATA, 16'h00c3);
    repeat (200) @(posedge ref_clk);
    chk({15'h0000, uart_txd}, 16'h0001);
    u_serial_peer.set_cts(1'b0);
    wait_got(n0 + 1);
    chk({8'h00, u_serial_peer.got[7:0]}, 16'h00c3);
    u_serial_peer.send({3'b111, 8'ha7, 1'b0});
    chk({15'h0000, uart_rts_n}, 16'h0001);
    rchk(`REG_STATUS, 16'h0002, 16'h0002);
    rchk(`REG_RXDATA, 16'hffff, 16'h00a7);
    rchk(`REG_STATUS, 16'h0002, 16'h0000);
    repeat (3) @(posedge ref_clk);
    chk({15'h0000, uart_rts_n}, 16'h0000);
end
endtask
// Parity, framing and overrun errors; parity and framing cleared by writing ones
task t_rxerr;
begin
    wr(`REG_CTRL, 16'h0001);
    u_serial_peer.send({2'b11, ~^8'h3c, 8'h3c, 1'b0});
    rchk(`REG_STATUS, 16'h001c, 16'h0004);
    rchk(`REG_RXDATA, 16'hffff, 16'h003c);
    wr(`REG_STATUS, 16'h001c);
    u_serial_peer.send({2'b10, ^8'h5e, 8'h5e, 1'b0});
    rchk(`REG_STATUS, 16'h001c, 16'h0008);
    wr(`REG_STATUS, 16'h001c);
    rchk(`REG_STATUS, 16'h001c, 16'h0000);
    u_serial_peer.send({2'b11, ^8'h81, 8'h81, 1'b0});
    u_serial_peer.send({2'b11, ^8'h42, 8'h42, 1'b0});
    rchk(`REG_STATUS, 16'h001c, 16'h0010);
    rchk(`REG_RXDATA, 16'hffff, 16'h0042);
end
endtask
// Break between two and three units long, and well past, against a two-unit timeout
task t_break;
begin
    wr(`REG_BRK_TIMEOUT, 16'h0002);
    n0 = pulses;
    u_serial_peer.hold_low(45);
    repeat (10) @(posedge ref_clk);
    chk(pulses[15:0], n0[15:0]);
    u_serial_peer.hold_low(80);
    repeat (10) @(posedge ref_clk);
    chk(pulses[15:0], n0[15:0] + 16'h1);
end
endtask
task t_sendbrk;
begin
    wr(`REG_CTRL, 16'h0010);
    repeat (30) @(posedge ref_clk);
    chk({15'h0000, uart_txd}, 16'h0000);
    wr(`REG_CTRL, 16'h0000);
    repeat (30) @(posedge ref_clk);
    chk({15'h0000, uart_txd}, 16'h0001);
end
endtask
task test_done;
begin
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
end
endtask
// Main sequence after six cycles of reset
initial begin
    // Raised at time zero by NBA so the asynchronous reset sees a real edge
    sys_rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_tx;
    t_flow;
    t_rxerr;
    t_break;
    t_sendbrk;
    test_done;
end
// Watchdog well beyond the expected run length
initial begin
    #(50 * 40000);
    miscompares = miscompares + 1;
    test_done;
end
endmodule
